/* File: rtl/cpf_core_pipe.sv */
// Function
// [RQ1] Execute stage: ALU, branch test, multiply/divide start, address, cache lookup start.
// [RQ2] Memory stage: translate data address, finish cache lookup, align load data.
// [RQ3] Writeback stage writes ALU and load results into integer registers.
// [RQ4] Four privilege levels; kernel entered on reset and every exception (debugEnter in the same cycle wins and enters debug).
// [RQ5] Kernel reaches everything; user limited in address space and system access.
// [RQ6] Single-cycle logical, shift, add, subtract on one shared 64-bit adder.
// [RQ7] Thirty-two 64-bit integer registers, two reads, two writes, full bypass. Code does not bypass the second write port (mduWr).
// [RQ8] Correct prediction costs nothing; misprediction costs exactly one bubble.
// [RQ9] Thirty-two 64-bit floating registers, single and double formats.
// [RQ10] Seven floating stages: decode, mult tree, mult done, add, add final, pack, write.
// [RQ11] Floating results forwarded straight to dependent floating instructions.
// [RQ12] Floating pipeline keeps moving while the integer pipeline stalls.
// [RQ13] Floating arithmetic in program order; loads and stores may finish out of order.
// [RQ14] Floating exceptions always precise.
// [RQ15] One floating arithmetic and one floating load/store may issue together.
// [RQ16] Fused multiply-add rounds after the multiply.
// [RQ17] Flush-to-zero mode turns denormal results into zero.
// [RQ18] Most floating ops latency 4, repeat 1; conversions 5 or 6.
// [RQ19] Double multiply uses tree twice: latency 5, repeat 2.
// [RQ20] Reciprocal, root and divide latencies and repeat intervals as tabled.
// [RQ21] Compare usable by floating after 1 cycle, others after 2.
// [RQ22] Floating load latency 3, register moves latency 2, repeat 1.
// [RQ23] Interlock dependents until latency; stall repeat issue until interval passes.
// [RQ24] Denormal result without flush-to-zero raises precise unimplemented exception.
`timescale 1ns/100ps
`default_nettype none
`include "cpf_params.svh"
module cpf_core_pipe
  import cpf_pkg::*;
#(
  parameter int PA_BITS = `CPF_PA_BITS,
  parameter int USER_VA_BITS = `CPF_USER_VA_BITS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Integer dispatch
  input wire cpf_ex_s exIn,
  output logic intStall,
  output logic redirect,
  output logic [63:0] redirectPc,
  // Multiply/divide start and second write port
  output logic mulDivStart,
  input wire cpf_wr_s mduWr,
  // Data cache and translation
  output logic dcLookup,
  output logic dcWrite,
  output logic [63:0] dcVaddr,
  output logic [63:0] dcWdata,
  input wire logic [63:0] dcRdata,
  output logic [PA_BITS-1:0] physAddr,
  // Privilege
  input wire logic excIn,
  input wire logic debugEnter,
  input wire logic modeRetValid,
  input wire cpf_mode_e modeRet,
  input wire logic userSysEnable,
  output cpf_mode_e mode,
  output logic addrFault,
  output logic sysFault,
  // Floating issue
  input wire cpf_fp_s fpIn,
  output logic fpReady,
  input wire cpf_fpls_s fpLs,
  output logic fpLsReady,
  output logic fpCcIntReady,
  input wire cpf_wr_s fpExtWr,
  input wire logic flushToZero,
  output logic fpUnimpl
);
  localparam int NSTG = `CPF_FP_STAGES;
  localparam int PK = `CPF_FP_PACK_IDX;
  // ----------------------------------------
  // Integer register file and bypass
  // ----------------------------------------
  logic [63:0] integer_register_file [`CPF_NREG];
  logic mValid_reg, mLoad_reg, mStore_reg, mUns_reg;
  logic [1:0] mSize_reg;
  logic [4:0] mRd_reg, wRd_reg;
  logic [63:0] mRes_reg, mVaddr_reg, mStData_reg, wData_reg;
  logic wValid_reg;
  logic [63:0] opA, opB, regB;
  function automatic logic [63:0] readFwd(input logic [4:0] r, input logic [63:0] fileVal,
      input logic mv, input logic ml, input logic [4:0] mr, input logic [63:0] md,
      input logic wv, input logic [4:0] wr, input logic [63:0] wd);
    if (r == 5'h0) readFwd = 64'h0;
    else if (mv && !ml && mr == r) readFwd = md;
    else if (wv && wr == r) readFwd = wd;
    else readFwd = fileVal;
  endfunction
  // [RQ7] Bypass from memory (non-load results only) and writeback; second-port writes are not bypassed
  assign opA = readFwd(exIn.rs, integer_register_file[exIn.rs], mValid_reg, mLoad_reg, mRd_reg, mRes_reg,
    wValid_reg, wRd_reg, wData_reg);
  assign regB = readFwd(exIn.rt, integer_register_file[exIn.rt], mValid_reg, mLoad_reg, mRd_reg, mRes_reg,
    wValid_reg, wRd_reg, wData_reg);
  assign opB = exIn.useImm ? exIn.imm : regB;
  // Load data exists only after memory stage, so a direct consumer waits one cycle
  assign intStall = exIn.valid && mValid_reg && mLoad_reg && mRd_reg != 5'h0 &&
    (mRd_reg == exIn.rs || ((!exIn.useImm || exIn.isStore) && mRd_reg == exIn.rt));
  // [RQ3] Writeback port and second port
  always_ff @(posedge clk) begin
    if (wValid_reg && wRd_reg != 5'h0) begin
      integer_register_file[wRd_reg] <= wData_reg;
    end
    if (mduWr.valid && mduWr.idx != 5'h0 && !(wValid_reg && wRd_reg == mduWr.idx)) begin
      integer_register_file[mduWr.idx] <= mduWr.data;
    end
  end
  // ----------------------------------------
  // Execute stage
  // ----------------------------------------
  logic exGo, isSub, brTaken, userBad;
  logic [63:0] sum, aluRes;
  assign exGo = exIn.valid && !intStall;
  assign isSub = (exIn.aluOp == CPF_SUB);
  // [RQ6] One adder for results and addresses
  assign sum = opA + (isSub ? ~opB : opB) + {63'h0, isSub};
  always_comb begin
    case (exIn.aluOp)
      CPF_AND: aluRes = opA & opB;
      CPF_OR: aluRes = opA | opB;
      CPF_XOR: aluRes = opA ^ opB;
      CPF_NOR: aluRes = ~(opA | opB);
      CPF_SLL: aluRes = opA << opB[5:0];
      CPF_SRL: aluRes = opA >> opB[5:0];
      CPF_SRA: aluRes = $signed(opA) >>> opB[5:0];
      default: aluRes = sum;
    endcase
  end
  // [RQ1] Branch condition resolved here
  always_comb begin
    case (exIn.brCond)
      2'h0: brTaken = (opA == regB);
      2'h1: brTaken = (opA != regB);
      2'h2: brTaken = opA[63];
      default: brTaken = !opA[63];
    endcase
  end
  // [RQ8] Only a wrong guess redirects
  assign redirect = exGo && exIn.isBranch && (brTaken != exIn.predTaken);
  assign redirectPc = brTaken ? exIn.brTarget : exIn.fallPc;
  // [RQ5] User space and system access limits
  assign userBad = (mode == CPF_USER) && (sum[63:USER_VA_BITS] != '0);
  assign addrFault = exGo && (exIn.isLoad || exIn.isStore) && userBad;
  assign sysFault = exGo && exIn.sysAccess && mode == CPF_USER && !userSysEnable;
  // [RQ1] Start multiply/divide and cache lookup
  assign mulDivStart = exGo && exIn.aluOp == CPF_AND && exIn.rd == 5'h0 && exIn.sysAccess;
  assign dcLookup = exGo && (exIn.isLoad || exIn.isStore) && !userBad;
  assign dcWrite = dcLookup && exIn.isStore;
  assign dcVaddr = sum;
  assign dcWdata = regB;
  // ----------------------------------------
  // Memory and writeback stages
  // ----------------------------------------
  logic [63:0] ldAligned, ldShift;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mValid_reg <= 1'b0;
      mLoad_reg <= 1'b0;
      mStore_reg <= 1'b0;
      mUns_reg <= 1'b0;
      mSize_reg <= 2'h0;
      mRd_reg <= 5'h0;
      mRes_reg <= 64'h0;
      mVaddr_reg <= 64'h0;
      mStData_reg <= 64'h0;
    end else begin
      mValid_reg <= exGo && !addrFault && !sysFault && !exIn.isBranch && !exIn.isStore;
      mLoad_reg <= exIn.isLoad;
      mStore_reg <= exIn.isStore;
      mUns_reg <= exIn.loadUnsigned;
      mSize_reg <= exIn.size;
      mRd_reg <= exIn.rd;
      mRes_reg <= aluRes;
      mVaddr_reg <= sum;
      mStData_reg <= regB;
    end
  end
  // [RQ2] Fixed mapping translation
  assign physAddr = mVaddr_reg[PA_BITS-1:0];
  // [RQ2] Load alignment and extension
  assign ldShift = dcRdata >> {mVaddr_reg[2:0], 3'h0};
  always_comb begin
    case (mSize_reg)
      2'h0: ldAligned = {{56{ldShift[7] & !mUns_reg}}, ldShift[7:0]};
      2'h1: ldAligned = {{48{ldShift[15] & !mUns_reg}}, ldShift[15:0]};
      2'h2: ldAligned = {{32{ldShift[31] & !mUns_reg}}, ldShift[31:0]};
      default: ldAligned = dcRdata;
    endcase
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wValid_reg <= 1'b0;
      wRd_reg <= 5'h0;
      wData_reg <= 64'h0;
    end else begin
      wValid_reg <= mValid_reg;
      wRd_reg <= mRd_reg;
      wData_reg <= mLoad_reg ? ldAligned : mRes_reg;
    end
  end
  // ----------------------------------------
  // Privilege mode
  // ----------------------------------------
  logic excTaken;
  assign excTaken = excIn || addrFault || sysFault || fpUnimpl;
  // [RQ4] Kernel on reset and on exception
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mode <= CPF_KERNEL;
    end else if (debugEnter) begin
      mode <= CPF_DEBUG;
    end else if (excTaken) begin
      mode <= CPF_KERNEL;
    end else if (modeRetValid) begin
      mode <= modeRet;
    end
  end
  // ----------------------------------------
  // Floating pipeline
  // ----------------------------------------
  logic [63:0] fpr [`CPF_NREG];
  logic [NSTG-1:0] sV_reg;
  logic [4:0] sFd_reg [NSTG];
  logic [63:0] sData_reg [NSTG];
  logic sDbl_reg [NSTG];
  logic fpFire, lsFire, denorm;
  logic [63:0] fsVal, fRes, pk;
  logic [NSTG-1:0] kill;
  // [RQ13] [RQ23] In-order interlocked issue
  cpf_fp_sched #(
    .NREG(`CPF_NREG)
  ) uSched (
    .clk(clk),
    .reset_n(reset_n),
    .arIn(fpIn),
    .arReady(fpReady),
    .lsIn(fpLs),
    .lsReady(fpLsReady),
    .ccIntReady(fpCcIntReady),
    .flush(fpUnimpl)
  );
  assign fpFire = fpIn.valid && fpReady && fpIn.op != CPF_FOP_EXT && fpIn.cls != CPF_F_CMP;
  assign lsFire = fpLs.valid && fpLsReady;
  // [RQ11] Forward, youngest first, once a dependent may issue
  always_comb begin
    fsVal = fpr[fpIn.fs];
    for (int i = NSTG - 1; i >= `CPF_LAT_BASIC - 1; i--) begin
      if (sV_reg[i] && sFd_reg[i] == fpIn.fs) fsVal = sData_reg[i];
    end
  end
  // [RQ9] Sign handling in either format
  always_comb begin
    case (fpIn.op)
      CPF_FOP_ABS: fRes = fpIn.dbl ? {1'b0, fsVal[62:0]} : {32'h0, 1'b0, fsVal[30:0]};
      CPF_FOP_NEG: fRes = fpIn.dbl ? {~fsVal[63], fsVal[62:0]} : {32'h0, ~fsVal[31], fsVal[30:0]};
      default: fRes = fsVal;
    endcase
  end
  // Denormal: exponent zero, fraction nonzero
  assign pk = sData_reg[PK];
  assign denorm = sV_reg[PK] && (sDbl_reg[PK] ? (pk[62:52] == 11'h0 && pk[51:0] != '0) :
    (pk[30:23] == 8'h0 && pk[22:0] != '0));
  // [RQ24] Unimplemented result exception
  assign fpUnimpl = denorm && !flushToZero;
  // [RQ14] Younger stages squashed with the faulting one
  always_comb begin
    for (int i = 0; i < NSTG; i++) kill[i] = fpUnimpl && i <= PK;
  end
  // [RQ10] Seven stage advance
  // [RQ12] No integer stall term here
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sV_reg <= '0;
    end else begin
      sV_reg[0] <= fpFire && !fpUnimpl;
      for (int i = 1; i < NSTG; i++) sV_reg[i] <= sV_reg[i-1] && !kill[i-1];
    end
  end
  always_ff @(posedge clk) begin
    sFd_reg[0] <= fpIn.fd;
    sData_reg[0] <= fRes;
    sDbl_reg[0] <= fpIn.dbl;
    for (int i = 1; i < NSTG; i++) begin
      sFd_reg[i] <= sFd_reg[i-1];
      sDbl_reg[i] <= sDbl_reg[i-1];
      // [RQ17] Flush denormal to signed zero
      if (i == PK + 1 && denorm && flushToZero) begin
        sData_reg[i] <= sDbl_reg[PK] ? {pk[63], 63'h0} : {32'h0, pk[31], 31'h0};
      end else begin
        sData_reg[i] <= sData_reg[i-1];
      end
    end
  end
  // [RQ22] Loads and moves written after their latency
  logic [1:0] lsV_reg [2];
  logic [4:0] lsFt_reg [2];
  logic [63:0] lsD_reg [2];
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      lsV_reg[0] <= 2'h0;
      lsV_reg[1] <= 2'h0;
    end else begin
      lsV_reg[0] <= {lsFire && fpLs.isLoad && !fpLs.isMove, lsFire && fpLs.isLoad && fpLs.isMove};
      lsV_reg[1] <= {lsV_reg[0][1], 1'b0};
    end
  end
  always_ff @(posedge clk) begin
    lsFt_reg[0] <= fpLs.ft;
    lsD_reg[0] <= fpLs.data;
    lsFt_reg[1] <= lsFt_reg[0];
    lsD_reg[1] <= lsD_reg[0];
  end
  // [RQ13] [RQ16] Loads land early; fused results arrive already rounded
  always_ff @(posedge clk) begin
    if (sV_reg[NSTG-1]) begin
      fpr[sFd_reg[NSTG-1]] <= sData_reg[NSTG-1];
    end
    if (fpExtWr.valid) begin
      fpr[fpExtWr.idx] <= fpExtWr.data;
    end
    if (lsV_reg[1][1]) begin
      fpr[lsFt_reg[1]] <= lsD_reg[1];
    end
    if (lsV_reg[0][0]) begin
      fpr[lsFt_reg[0]] <= lsD_reg[0];
    end
  end
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence sLoadUse;
    mValid_reg && mLoad_reg && exIn.valid && mRd_reg == exIn.rs && mRd_reg != 5'h0;
  endsequence
  a_load_use: assert property (@(posedge clk) disable iff (!reset_n)
    sLoadUse |-> intStall ##1 !mValid_reg) // [RQ7]
    else $error("load consumer not held one cycle");
  a_reset_kernel: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(reset_n) |-> mode == CPF_KERNEL) // [RQ4]
    else $error("mode not kernel after reset");
  a_exc_kernel: assert property (@(posedge clk) disable iff (!reset_n)
    excTaken && !debugEnter |=> mode == CPF_KERNEL) // [RQ4]
    else $error("exception did not enter kernel");
  a_user_fault: assert property (@(posedge clk) disable iff (!reset_n)
    addrFault |-> !dcLookup && mode == CPF_USER) // [RQ5]
    else $error("user access beyond its space reached cache");
  a_good_guess: assert property (@(posedge clk) disable iff (!reset_n)
    exGo && exIn.isBranch && brTaken == exIn.predTaken |-> !redirect) // [RQ8]
    else $error("correct prediction caused a bubble");
  a_wb_result: assert property (@(posedge clk) disable iff (!reset_n)
    exGo && !exIn.isLoad && !exIn.isStore && !exIn.isBranch && !sysFault
    |-> ##2 wValid_reg && wData_reg == $past(aluRes, 2)) // [RQ3]
    else $error("ALU result not at writeback two cycles later");
  a_fp_depth: assert property (@(posedge clk) disable iff (!reset_n)
    fpFire && !fpUnimpl ##1 (!fpUnimpl)[*7] |-> sV_reg[NSTG-1]) // [RQ10]
    else $error("floating op did not reach writeback stage");
  a_fp_precise: assert property (@(posedge clk) disable iff (!reset_n)
    fpUnimpl |=> sV_reg[PK+1:0] == '0) // [RQ14]
    else $error("younger floating op survived exception");
  a_fp_ftz: assert property (@(posedge clk) disable iff (!reset_n)
    denorm && flushToZero |=> sData_reg[PK+1][62:0] == 63'h0 || !sDbl_reg[PK+1]) // [RQ17]
    else $error("denormal not flushed");
endmodule // cpf_core_pipe
`default_nettype wire

/* File: rtl/cpf_params.svh */
`ifndef CPF_PARAMS_SVH
`define CPF_PARAMS_SVH
// ----------------------------------------
// Sizes
// ----------------------------------------
`define CPF_XLEN 64
`define CPF_NREG 32
`define CPF_PA_BITS 36
`define CPF_USER_VA_BITS 40
`define CPF_FP_STAGES 7
`define CPF_FP_PACK_IDX 5
// ----------------------------------------
// Floating-point latency / repeat, cycles
// ----------------------------------------
`define CPF_LAT_BASIC 4
`define CPF_RPT_BASIC 1
`define CPF_LAT_MULD 5
`define CPF_RPT_MULD 2
`define CPF_LAT_CVTSD 6
`define CPF_LAT_CVTI 5
`define CPF_LAT_RECIPS 13
`define CPF_RPT_RECIPS 10
`define CPF_LAT_RECIPD 25
`define CPF_RPT_RECIPD 21
`define CPF_LAT_RSQRTS 17
`define CPF_RPT_RSQRTS 14
`define CPF_LAT_RSQRTD 35
`define CPF_RPT_RSQRTD 31
`define CPF_LAT_DIVS 17
`define CPF_RPT_DIVS 14
`define CPF_LAT_DIVD 32
`define CPF_RPT_DIVD 29
`define CPF_LAT_CMP_FP 1
`define CPF_LAT_CMP_INT 2
`define CPF_LAT_LOAD 3
`define CPF_LAT_MOVE 2
`endif

/* File: rtl/cpf_pkg.sv */
package cpf_pkg;
  typedef enum logic [1:0] {
    CPF_USER = 2'b00, CPF_SUPER = 2'b01, CPF_KERNEL = 2'b10, CPF_DEBUG = 2'b11
  } cpf_mode_e;
  typedef enum logic [3:0] {
    CPF_AND = 4'h0, CPF_OR = 4'h1, CPF_XOR = 4'h2, CPF_NOR = 4'h3, CPF_ADD = 4'h4,
    CPF_SUB = 4'h5, CPF_SLL = 4'h6, CPF_SRL = 4'h7, CPF_SRA = 4'h8
  } cpf_aluop_e;
  typedef enum logic [3:0] {
    CPF_F_BASIC = 4'h0, CPF_F_MULD = 4'h1, CPF_F_CVTSD = 4'h2, CPF_F_CVTI = 4'h3,
    CPF_F_RECIPS = 4'h4, CPF_F_RECIPD = 4'h5, CPF_F_RSQRTS = 4'h6, CPF_F_RSQRTD = 4'h7,
    CPF_F_DIVS = 4'h8, CPF_F_DIVD = 4'h9, CPF_F_CMP = 4'ha
  } cpf_fpcls_e;
  typedef enum logic [1:0] {
    CPF_FOP_MOV = 2'b00, CPF_FOP_ABS = 2'b01, CPF_FOP_NEG = 2'b10, CPF_FOP_EXT = 2'b11
  } cpf_fop_e;
  typedef struct packed {
    logic valid;
    cpf_aluop_e aluOp;
    logic [4:0] rs;
    logic [4:0] rt;
    logic [4:0] rd;
    logic useImm;
    logic [63:0] imm;
    logic isLoad;
    logic isStore;
    logic [1:0] size;
    logic loadUnsigned;
    logic isBranch;
    logic [1:0] brCond;
    logic predTaken;
    logic [63:0] brTarget;
    logic [63:0] fallPc;
    logic sysAccess;
  } cpf_ex_s;
  typedef struct packed {
    logic valid;
    cpf_fpcls_e cls;
    cpf_fop_e op;
    logic dbl;
    logic [4:0] fd;
    logic [4:0] fs;
    logic [4:0] ft;
  } cpf_fp_s;
  typedef struct packed {
    logic valid;
    logic isMove;
    logic isLoad;
    logic [4:0] ft;
    logic [63:0] data;
  } cpf_fpls_s;
  typedef struct packed {
    logic valid;
    logic [4:0] idx;
    logic [63:0] data;
  } cpf_wr_s;
endpackage

/* File: rtl/cpf_fp_sched.sv */
`timescale 1ns/100ps
`default_nettype none
`include "cpf_params.svh"
module cpf_fp_sched
  import cpf_pkg::*;
#(
  parameter int NREG = `CPF_NREG
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Arithmetic issue
  input wire cpf_fp_s arIn,
  output logic arReady,
  // Load, store and move issue
  input wire cpf_fpls_s lsIn,
  output logic lsReady,
  // Compare result use
  output logic ccIntReady,
  input wire logic flush
);
  // [RQ18] [RQ20] Latency by class
  function automatic logic [5:0] latOf(input cpf_fpcls_e c);
    case (c)
      CPF_F_MULD: latOf = 6'(`CPF_LAT_MULD);
      CPF_F_CVTSD: latOf = 6'(`CPF_LAT_CVTSD);
      CPF_F_CVTI: latOf = 6'(`CPF_LAT_CVTI);
      CPF_F_RECIPS: latOf = 6'(`CPF_LAT_RECIPS);
      CPF_F_RECIPD: latOf = 6'(`CPF_LAT_RECIPD);
      CPF_F_RSQRTS: latOf = 6'(`CPF_LAT_RSQRTS);
      CPF_F_RSQRTD: latOf = 6'(`CPF_LAT_RSQRTD);
      CPF_F_DIVS: latOf = 6'(`CPF_LAT_DIVS);
      CPF_F_DIVD: latOf = 6'(`CPF_LAT_DIVD);
      CPF_F_CMP: latOf = 6'(`CPF_LAT_CMP_FP);
      default: latOf = 6'(`CPF_LAT_BASIC);
    endcase
  endfunction
  function automatic logic [5:0] rptOf(input cpf_fpcls_e c);
    case (c)
      CPF_F_MULD: rptOf = 6'(`CPF_RPT_MULD);
      CPF_F_RECIPS: rptOf = 6'(`CPF_RPT_RECIPS);
      CPF_F_RECIPD: rptOf = 6'(`CPF_RPT_RECIPD);
      CPF_F_RSQRTS: rptOf = 6'(`CPF_RPT_RSQRTS);
      CPF_F_DIVS: rptOf = 6'(`CPF_RPT_DIVS);
      CPF_F_RSQRTD: rptOf = 6'(`CPF_RPT_RSQRTD);
      CPF_F_DIVD: rptOf = 6'(`CPF_RPT_DIVD);
      default: rptOf = 6'(`CPF_RPT_BASIC);
    endcase
  endfunction
  logic [5:0] regCnt_reg [NREG];
  logic [5:0] unitCnt_reg;
  logic [5:0] ccFpCnt_reg;
  logic [1:0] ccIntCnt_reg;
  logic arFire;
  logic lsFire;
  logic isCmp;
  assign isCmp = (arIn.cls == CPF_F_CMP);
  // [RQ23] Dependency interlock
  assign arReady = (regCnt_reg[arIn.fs] == 6'h0) && (regCnt_reg[arIn.ft] == 6'h0) &&
    (isCmp || regCnt_reg[arIn.fd] == 6'h0) && (unitCnt_reg == 6'h0) && (ccFpCnt_reg == 6'h0);
  // [RQ15] Same-cycle dual issue
  assign lsReady = (regCnt_reg[lsIn.ft] == 6'h0) && !(arFire && !isCmp && arIn.fd == lsIn.ft);
  assign arFire = arIn.valid && arReady;
  assign lsFire = lsIn.valid && lsReady;
  assign ccIntReady = (ccIntCnt_reg == 2'h0);
  genvar g;
  generate
    for (g = 0; g < NREG; g++) begin : gCnt
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          regCnt_reg[g] <= 6'h0;
        end else if (flush) begin
          regCnt_reg[g] <= 6'h0;
        end else if (arFire && !isCmp && arIn.fd == 5'(g)) begin
          regCnt_reg[g] <= latOf(arIn.cls) - 6'h1;
        // [RQ22] Load and move latency
        end else if (lsFire && lsIn.isLoad && lsIn.ft == 5'(g)) begin
          regCnt_reg[g] <= lsIn.isMove ? 6'(`CPF_LAT_MOVE - 1) : 6'(`CPF_LAT_LOAD - 1);
        end else if (regCnt_reg[g] != 6'h0) begin
          regCnt_reg[g] <= regCnt_reg[g] - 6'h1;
        end
      end
    end
  endgenerate
  // [RQ19] Repeat interval
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      unitCnt_reg <= 6'h0;
    end else if (arFire) begin
      unitCnt_reg <= rptOf(arIn.cls) - 6'h1;
    end else if (unitCnt_reg != 6'h0) begin
      unitCnt_reg <= unitCnt_reg - 6'h1;
    end
  end
  // [RQ21] Compare result timing
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ccFpCnt_reg <= 6'h0;
      ccIntCnt_reg <= 2'h0;
    end else if (arFire && isCmp) begin
      ccFpCnt_reg <= 6'(`CPF_LAT_CMP_FP - 1);
      ccIntCnt_reg <= 2'(`CPF_LAT_CMP_INT - 1);
    end else begin
      ccFpCnt_reg <= (ccFpCnt_reg != 6'h0) ? ccFpCnt_reg - 6'h1 : 6'h0;
      ccIntCnt_reg <= (ccIntCnt_reg != 2'h0) ? ccIntCnt_reg - 2'h1 : 2'h0;
    end
  end
  // [RQ23] Repeat stall holds
  a_repeat_hold: assert property (@(posedge clk) disable iff (!reset_n)
    arFire && arIn.cls == CPF_F_MULD && !flush |=> !arReady) // [RQ19]
    else $error("double multiply reissued inside repeat interval");
  a_cmp_int_wait: assert property (@(posedge clk) disable iff (!reset_n)
    arFire && isCmp && !flush |=> !ccIntReady ##1 (ccIntReady || $past(arFire && isCmp))) // [RQ21]
    else $error("compare result timing to integer side wrong");
endmodule // cpf_fp_sched
`default_nettype wire

/* File: tb/cpf_dcache_model.sv */
`timescale 1ns/100ps
`default_nettype none
module cpf_dcache_model (
  // Clock and lookup
  input wire logic clk,
  input wire logic dcLookup,
  input wire logic [63:0] dcVaddr,
  // Load data
  output logic [63:0] dcRdata
);
  // ----------------------------------------
  // Lookup answer
  // ----------------------------------------
  // Idle cycles invert data, so a stale word never passes for an answer
  initial dcRdata = 64'h0;
  always @(posedge clk) begin
    if (dcLookup) begin
      dcRdata <= dcVaddr ^ 64'h5a5a_0000_0000_a5a5;
    end else begin
      dcRdata <= ~dcRdata;
    end
  end
endmodule // cpf_dcache_model
`default_nettype wire

/* File: tb/tb_core_pipeline_fpu_timing.sv */
`timescale 1ns/100ps
`default_nettype none
`include "cpf_params.svh"
module tb_core_pipeline_fpu_timing;
  import cpf_pkg::*;
  cpf_ex_s exIn;
  cpf_fp_s fpIn;
  cpf_fpls_s fpLs;
  cpf_wr_s mduWr, fpExtWr;
  cpf_mode_e modeRet, mode;
  logic clk = 0, reset_n = 0, excIn = 0, debugEnter = 0, modeRetValid = 0, userSysEnable = 0, flushToZero = 0;
  logic intStall, redirect, mulDivStart, dcLookup, dcWrite, addrFault, sysFault;
  logic fpReady, fpLsReady, fpCcIntReady, fpUnimpl;
  logic [63:0] redirectPc, dcVaddr, dcWdata, dcRdata, a, b;
  logic [35:0] physAddr;
  int fails = 0, cmp_count = 0, n;
  cpf_fpcls_e cl[10] = '{CPF_F_MULD, CPF_F_DIVS, CPF_F_DIVD, CPF_F_RECIPS, CPF_F_RECIPD,
    CPF_F_RSQRTS, CPF_F_RSQRTD, CPF_F_BASIC, CPF_F_CVTSD, CPF_F_CVTI};
  bit dp[10] = '{0, 0, 0, 0, 0, 0, 0, 1, 1, 1};
  int xp[10] = '{`CPF_RPT_MULD-1, `CPF_RPT_DIVS-1, `CPF_RPT_DIVD-1, `CPF_RPT_RECIPS-1, `CPF_RPT_RECIPD-1,
    `CPF_RPT_RSQRTS-1, `CPF_RPT_RSQRTD-1, `CPF_LAT_BASIC-1, `CPF_LAT_CVTSD-1, `CPF_LAT_CVTI-1};

  cpf_core_pipe dut (.clk, .reset_n, .exIn, .intStall, .redirect, .redirectPc, .mulDivStart, .mduWr,
    .dcLookup, .dcWrite, .dcVaddr, .dcWdata, .dcRdata, .physAddr, .excIn, .debugEnter, .modeRetValid,
    .modeRet, .userSysEnable, .mode, .addrFault, .sysFault, .fpIn, .fpReady, .fpLs, .fpLsReady,
    .fpCcIntReady, .fpExtWr, .flushToZero, .fpUnimpl);
  cpf_dcache_model cache (.clk, .dcLookup, .dcVaddr, .dcRdata);

  always #2 clk = ~clk;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [63:0] ld(logic [63:0] v);
    return v ^ 64'h5a5a_0000_0000_a5a5;
  endfunction
  task automatic cyc(int k);
    repeat (k) @(negedge clk);
  endtask
  task automatic chk(string s, logic [63:0] e, logic [63:0] g);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic ex(logic ldOp, logic [4:0] rs, logic [4:0] rd, logic [63:0] imm);
    exIn = '0;
    exIn.valid = 1;
    exIn.aluOp = CPF_ADD;
    exIn.isLoad = ldOp;
    exIn.useImm = ldOp;
    exIn.rs = rs;
    exIn.rt = ldOp ? rd : 5'd2;
    exIn.rd = rd;
    exIn.imm = imm;
    exIn.size = 2'b11;
    #1;
  endtask

  task automatic toUser();
    modeRet = CPF_USER;
    modeRetValid = 1;
    cyc(1);
    modeRetValid = 0;
  endtask

  // Hang guard
  initial begin
    #100000;
    fails++;
    summarize();
  end

  initial begin
    exIn = '0;
    fpIn = '0;
    fpLs = '0;
    mduWr = '0;
    fpExtWr = '0;
    modeRet = CPF_USER;
    void'($urandom(32'h1866a5f5));
    cyc(12);
    reset_n = 1;
    chk("mode", CPF_KERNEL, mode);
    // ----------------------------------------
    // Adder, bypass, load path
    // ----------------------------------------
    a = {$urandom, $urandom};
    b = {$urandom, $urandom};
    mduWr = '{1'b1, 5'd1, a};
    cyc(1);
    mduWr = '{1'b1, 5'd2, b};
    cyc(1);
    mduWr.valid = 0;
    cyc(2);
    ex(0, 1, 3, 0);
    cyc(1);
    ex(1, 3, 5, 0);
    chk("stall", 0, intStall);
    chk("vaddr", a + b, dcVaddr);
    chk("lookup", 1, dcLookup);
    cyc(1);
    ex(1, 5, 6, 64'h8);
    chk("loaduse", 1, intStall);
    chk("phys", (a + b) & 64'hf_ffff_ffff, physAddr);
    for (n = 0; n < 4 && intStall; n++) begin
      cyc(1);
      #1;
    end
    chk("ldaddr", ld(a + b) + 64'h8, dcVaddr);
    cyc(1);
    exIn = '0;
    exIn.valid = 1;
    exIn.isBranch = 1;
    exIn.brTarget = a;
    #1;
    chk("redirect", 1, redirect);
    chk("target", a, redirectPc);
    cyc(1);
    exIn.valid = 0;
    $display("done alu");
    // ----------------------------------------
    // Privilege levels
    // ----------------------------------------
    toUser();
    chk("user", CPF_USER, mode);
    ex(1, 0, 7, 64'h100_0000_0000);
    chk("fault", 1, addrFault);
    chk("nolookup", 0, dcLookup);
    cyc(1);
    exIn.valid = 0;
    chk("faultexc", CPF_KERNEL, mode);
    toUser();
    exIn = '0;
    exIn.valid = 1;
    exIn.sysAccess = 1;
    #1;
    chk("sysfault", 1, sysFault);
    chk("mdustart", 1, mulDivStart);
    cyc(1);
    exIn.valid = 0;
    chk("sysexc", CPF_KERNEL, mode);
    toUser();
    excIn = 1;
    cyc(1);
    excIn = 0;
    chk("exc", CPF_KERNEL, mode);
    debugEnter = 1;
    cyc(1);
    debugEnter = 0;
    chk("debug", CPF_DEBUG, mode);
    modeRet = CPF_SUPER;
    modeRetValid = 1;
    cyc(1);
    modeRetValid = 0;
    chk("super", CPF_SUPER, mode);
    $display("done mode");
    // ----------------------------------------
    // Floating repeat and latency
    // ----------------------------------------
    // Known operands; register 7 holds a denormal
    for (n = 2; n < 8; n++) begin
      fpExtWr = '{1'b1, 5'(n), n == 7 ? 64'h1 : 64'h3ff0_0000_3f80_0000};
      cyc(1);
    end
    fpExtWr.valid = 0;
    foreach (cl[k]) begin
      fpIn = '{1'b1, cl[k], CPF_FOP_ABS, 1'b0, 5'd1, 5'd2, 5'd3};
      fpIn.dbl = cl[k] inside {CPF_F_MULD, CPF_F_RECIPD, CPF_F_RSQRTD, CPF_F_DIVD, CPF_F_CVTSD};
      cyc(1);
      fpIn = '{1'b1, dp[k] ? CPF_F_BASIC : cl[k], CPF_FOP_NEG, fpIn.dbl, 5'd4, dp[k] ? 5'd1 : 5'd5, 5'd6};
      #1;
      for (n = 0; n < 60 && !fpReady; n++) begin
        cyc(1);
        #1;
      end
      chk("fpwait", xp[k], n);
      cyc(1);
      fpIn.valid = 0;
      cyc(40);
    end
    fpLs = '{1'b1, 1'b0, 1'b1, 5'd9, a};
    fpIn = '{1'b1, CPF_F_CMP, CPF_FOP_MOV, 1'b0, 5'd0, 5'd2, 5'd3};
    #1;
    chk("dual", 1, fpLsReady && fpReady);
    cyc(1);
    fpLs.valid = 0;
    fpIn.fs = 5'd9;
    #1;
    chk("ccint", 0, fpCcIntReady);
    chk("lsdep", 0, fpReady);
    fpIn.valid = 0;
    cyc(1);
    chk("ccint2", 1, fpCcIntReady);
    for (n = 0; n < 2; n++) begin
      flushToZero = n[0];
      fpIn = '{1'b1, CPF_F_BASIC, CPF_FOP_MOV, 1'b1, 5'd8, 5'd7, 5'd7};
      cyc(1);
      fpIn.valid = 0;
      cyc(5);
      chk("unimpl", !n[0], fpUnimpl);
      cyc(4);
    end
    $display("done fp");
    summarize();
  end
endmodule // tb_core_pipeline_fpu_timing
`default_nettype wire
